// *** design/fesp_pkg.sv ***
// Shared constants of the flash erase, suspend and power-down sequencer.
// Assumes a 20 ns system clock; times are converted to cycles here.
package fesp_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int NS_PER_US = 1000;

  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SECREG_ERASE = 8'h44;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SECREG_PROG = 8'h42;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;

  localparam logic [2:0] BYTES_BARE = 3'h1;
  localparam logic [2:0] BYTES_STATUS_MIN = 3'h2;
  localparam logic [2:0] BYTES_ADDR = 3'h4;
  localparam logic [2:0] BYTES_PROG_MIN = 3'h5;
  localparam logic [2:0] BYTES_SAT = 3'h7;

  localparam logic [23:0] SECTOR_MASK = 24'hfff000;
  localparam logic [23:0] BLK32_MASK = 24'hff8000;
  localparam logic [23:0] BLK64_MASK = 24'hff0000;
  localparam logic [23:0] CHIP_MASK = 24'h000000;

  // Durations in microseconds, neutral defaults
  localparam int SECTOR_ERASE_TIME_US = 50000;
  localparam int SMALL_BLOCK_ERASE_TIME_US = 100000;
  localparam int LARGE_BLOCK_ERASE_TIME_US = 150000;
  localparam int WHOLE_ARRAY_ERASE_TIME_US = 5000000;
  localparam int PAGE_PROGRAM_TIME_US = 500;
  localparam int SUSPEND_LATENCY_US = 20;
  localparam int POWERDOWN_ENTRY_TIME_US = 3;
  localparam int WAKE_RECOVERY_TIME_US = 3;

  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CYC_PER_US;
  localparam int SMALL_BLOCK_ERASE_CYC = SMALL_BLOCK_ERASE_TIME_US * CYC_PER_US;
  localparam int LARGE_BLOCK_ERASE_CYC = LARGE_BLOCK_ERASE_TIME_US * CYC_PER_US;
  localparam int WHOLE_ARRAY_ERASE_CYC = WHOLE_ARRAY_ERASE_TIME_US * CYC_PER_US;
  localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * CYC_PER_US;
  // Longest times round down, least times round up
  localparam int SUSPEND_LATENCY_CYC =
    (SUSPEND_LATENCY_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int POWERDOWN_ENTRY_CYC =
    (POWERDOWN_ENTRY_TIME_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int WAKE_RECOVERY_CYC =
    (WAKE_RECOVERY_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    S_IDLE, S_RUN, S_SUSP_WAIT, S_SUSPENDED, S_PD_ENTER, S_PD, S_WAKE
  } fesp_state_e;

  typedef enum logic [2:0] {
    KIND_NONE, KIND_SECTOR, KIND_BLK32, KIND_BLK64, KIND_CHIP, KIND_PROG
  } fesp_kind_e;
endpackage : fesp_pkg

// *** design/fesp_link_rx.sv ***
// Serial frame receiver on the host's serial clock.
// Assumes the serial clock idles while chip select is high, so the
// captured frame stays stable until the next frame begins.
`timescale 1ns/1ps
module fesp_link_rx (
  input wire logic sclk,
  input wire logic csN,
  input wire logic serialIn,
  output logic [7:0] frameOpcode,
  output logic [23:0] frameAddr,
  output logic [2:0] frameBytes,
  output logic [2:0] frameBits,
  output logic frameEmpty
);
  import fesp_pkg::*;

  typedef struct packed {
    logic [6:0] shift;
    logic [2:0] bits;
    logic [2:0] bytes;
    logic [7:0] opcode;
    logic [23:0] addr;
  } fesp_link_s;

  fesp_link_s st;
  fesp_link_s next_st;
  logic fresh;
  logic endEmpty;
  logic [7:0] byteVal;

  // Clock stops between frames, so the frame start is marked by chip select
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    next_st = st;
    if (fresh) begin
      next_st.bits = '0;
      next_st.bytes = '0;
    end
    byteVal = {next_st.shift, serialIn};
    if (next_st.bits == 3'h7) begin
      if (next_st.bytes == 3'h0) begin
        next_st.opcode = byteVal;
      end else if (next_st.bytes < BYTES_ADDR) begin
        next_st.addr = {next_st.addr[15:0], byteVal};
      end
      if (next_st.bytes != BYTES_SAT) begin
        next_st.bytes = next_st.bytes + 3'h1;
      end
    end
    next_st.shift = byteVal[6:0];
    next_st.bits = next_st.bits + 3'h1;
  end

  always_ff @(posedge sclk) begin
    st <= next_st;
  end

  assign frameOpcode = st.opcode;
  assign frameAddr = st.addr;
  assign frameBytes = st.bytes;
  assign frameBits = st.bits;
  // Taken as chip select rises; fresh still holds its frame value, so only a frame with no clock edge reads as empty
  always_ff @(posedge csN) begin
    endEmpty <= fresh;
  end

  assign frameEmpty = endEmpty;
endmodule : fesp_link_rx

// *** design/fesp_sequencer.sv ***
// Command sequencer for erase, suspend, resume and deep power-down.
// Assumes a protection decoder answers protectHit/protectAny in the
// same cycle from checkAddr/checkKind, and that the write-enable
// command logic pulses writeLatchSet. Erase itself happens in the
// array behind eraseGo; this block only times and gates it.
`timescale 1ns/1ps
module fesp_sequencer #(
  parameter int unsigned SECTOR_CYC = fesp_pkg::SECTOR_ERASE_CYC,
  parameter int unsigned BLK32_CYC = fesp_pkg::SMALL_BLOCK_ERASE_CYC,
  parameter int unsigned BLK64_CYC = fesp_pkg::LARGE_BLOCK_ERASE_CYC,
  parameter int unsigned CHIP_CYC = fesp_pkg::WHOLE_ARRAY_ERASE_CYC,
  parameter int unsigned PROG_CYC = fesp_pkg::PAGE_PROGRAM_CYC,
  parameter int unsigned SUSPEND_CYC = fesp_pkg::SUSPEND_LATENCY_CYC,
  parameter int unsigned PD_ENTRY_CYC = fesp_pkg::POWERDOWN_ENTRY_CYC,
  parameter int unsigned WAKE_CYC = fesp_pkg::WAKE_RECOVERY_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic serialIn,
  input wire logic writeLatchSet,
  input wire logic protectHit,
  input wire logic protectAny,
  output logic [23:0] checkAddr,
  output fesp_pkg::fesp_kind_e checkKind,
  output logic busy,
  output logic writeLatchFlag,
  output logic suspendFlag,
  output logic statusReadable,
  output logic powerDown,
  output logic eraseGo,
  output logic [23:0] eraseBase,
  output fesp_pkg::fesp_kind_e eraseKind,
  output logic programGo,
  output logic statusWriteGo
);
  import fesp_pkg::*;

  typedef struct packed {
    logic [2:0] csSync;
    fesp_state_e state;
    fesp_kind_e runKind;
    fesp_kind_e checkKind;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [2:0] nBytes;
    logic [2:0] nBits;
    logic empty;
    logic frameDone;
    logic [31:0] timer;
    logic [15:0] lat;
    logic busy;
    logic writeLatch;
    logic suspend;
    logic statusReadable;
    logic powerDown;
    logic eraseGo;
    logic [23:0] eraseBase;
    logic programGo;
    logic statusWriteGo;
  } fesp_seq_s;

  fesp_seq_s st;
  fesp_seq_s next_st;

  logic [7:0] frameOpcode;
  logic [23:0] frameAddr;
  logic [2:0] frameBytes;
  logic [2:0] frameBits;
  logic frameEmpty;

  logic csRise;
  logic cleanEnd;
  logic bareFrame;
  logic addrFrame;
  logic progFrame;
  logic statFrame;
  logic isErase;
  logic isProgram;

  fesp_link_rx u_link (
    .sclk(sclk),
    .csN(csN),
    .serialIn(serialIn),
    .frameOpcode(frameOpcode),
    .frameAddr(frameAddr),
    .frameBytes(frameBytes),
    .frameBits(frameBits),
    .frameEmpty(frameEmpty)
  );

  function automatic fesp_kind_e kindOf(input logic [7:0] op);
    fesp_kind_e k;
    k = KIND_NONE;
    case (op)
      OP_SECTOR_ERASE: k = KIND_SECTOR;
      OP_BLK32_ERASE: k = KIND_BLK32;
      OP_BLK64_ERASE: k = KIND_BLK64;
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: k = KIND_CHIP;
      OP_PAGE_PROG, OP_QUAD_PROG: k = KIND_PROG;
      default: k = KIND_NONE;
    endcase
    return k;
  endfunction : kindOf

  // Each size has its own self-timed duration
  function automatic logic [31:0] durOf(input fesp_kind_e k);
    logic [31:0] d;
    d = 32'(PROG_CYC);
    case (k)
      KIND_SECTOR: d = 32'(SECTOR_CYC);
      KIND_BLK32: d = 32'(BLK32_CYC);
      KIND_BLK64: d = 32'(BLK64_CYC);
      KIND_CHIP: d = 32'(CHIP_CYC);
      default: d = 32'(PROG_CYC);
    endcase
    return d;
  endfunction : durOf

  function automatic logic [23:0] maskOf(input fesp_kind_e k);
    logic [23:0] m;
    m = CHIP_MASK;
    case (k)
      KIND_SECTOR: m = SECTOR_MASK;
      KIND_BLK32: m = BLK32_MASK;
      KIND_BLK64: m = BLK64_MASK;
      default: m = CHIP_MASK;
    endcase
    return m;
  endfunction : maskOf

  // Frame record is stable once chip select has been high two cycles
  assign csRise = st.csSync[1] & ~st.csSync[2];
  assign cleanEnd = ~st.empty && (st.nBits == 3'h0);
  assign bareFrame = cleanEnd && (st.nBytes == BYTES_BARE);
  assign addrFrame = cleanEnd && (st.nBytes == BYTES_ADDR);
  assign progFrame = cleanEnd && (st.nBytes >= BYTES_PROG_MIN);
  assign statFrame = cleanEnd && (st.nBytes >= BYTES_STATUS_MIN);
  assign isErase = (st.opcode == OP_SECTOR_ERASE) ||
    (st.opcode == OP_BLK32_ERASE) || (st.opcode == OP_BLK64_ERASE) ||
    (st.opcode == OP_CHIP_ERASE_A) || (st.opcode == OP_CHIP_ERASE_B) ||
    (st.opcode == OP_SECREG_ERASE);
  assign isProgram = (st.opcode == OP_PAGE_PROG) ||
    (st.opcode == OP_QUAD_PROG) || (st.opcode == OP_SECREG_PROG);

  always_comb begin
    next_st = st;
    next_st.csSync = {st.csSync[1:0], csN};
    next_st.frameDone = 1'b0;
    next_st.eraseGo = 1'b0;
    next_st.programGo = 1'b0;
    next_st.statusWriteGo = 1'b0;

    if (csRise) begin
      next_st.opcode = frameOpcode;
      next_st.addr = frameAddr;
      next_st.nBytes = frameBytes;
      next_st.nBits = frameBits;
      next_st.empty = frameEmpty;
      next_st.checkKind = kindOf(frameOpcode);
      next_st.frameDone = 1'b1;
    end

    case (st.state)
      S_IDLE: begin
        if (st.frameDone) begin
          case (st.opcode)
            OP_SECTOR_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE: begin
              // Otherwise the opcode leaves all flags untouched
              if (addrFrame && st.writeLatch && !protectHit) begin
                next_st.state = S_RUN;
                next_st.runKind = st.checkKind;
                next_st.timer = durOf(st.checkKind);
                next_st.busy = 1'b1;
                next_st.eraseGo = 1'b1;
                next_st.eraseBase = st.addr & maskOf(st.checkKind);
              end
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
              if (bareFrame && st.writeLatch && !protectAny) begin
                next_st.state = S_RUN;
                next_st.runKind = KIND_CHIP;
                next_st.timer = durOf(KIND_CHIP);
                next_st.busy = 1'b1;
                next_st.eraseGo = 1'b1;
                next_st.eraseBase = CHIP_MASK;
              end
            end
            OP_PAGE_PROG, OP_QUAD_PROG: begin
              // Data path lives elsewhere; only the timing runs here
              if (progFrame && st.writeLatch && !protectHit) begin
                next_st.state = S_RUN;
                next_st.runKind = KIND_PROG;
                next_st.timer = durOf(KIND_PROG);
                next_st.busy = 1'b1;
                next_st.programGo = 1'b1;
              end
            end
            OP_STATUS_WRITE: begin
              if (statFrame && st.writeLatch) begin
                next_st.statusWriteGo = 1'b1;
              end
            end
            OP_POWER_DOWN: begin
              if (bareFrame) begin
                next_st.state = S_PD_ENTER;
                next_st.lat = 16'(PD_ENTRY_CYC);
              end
            end
            // Resume with the suspend flag clear does nothing
            OP_RESUME: next_st.state = S_IDLE;
            default: next_st.state = S_IDLE;
          endcase
        end
      end

      S_RUN: begin
        if (st.frameDone && st.opcode == OP_SUSPEND && bareFrame &&
            !st.suspend && st.runKind != KIND_CHIP) begin
          next_st.suspend = 1'b1;
          next_st.state = S_SUSP_WAIT;
          next_st.lat = 16'(SUSPEND_CYC);
        end else if (st.timer <= 32'h1) begin
          next_st.state = S_IDLE;
          next_st.busy = 1'b0;
          next_st.writeLatch = 1'b0;
          next_st.timer = '0;
        end else begin
          next_st.timer = st.timer - 32'h1;
        end
      end

      S_SUSP_WAIT: begin
        // Remaining time is frozen so resume finishes the same work
        if (st.lat <= 16'h1) begin
          next_st.busy = 1'b0;
          next_st.state = S_SUSPENDED;
        end else begin
          next_st.lat = st.lat - 16'h1;
        end
      end

      S_SUSPENDED: begin
        if (st.frameDone) begin
          if (st.opcode == OP_RESUME && bareFrame && !st.busy) begin
            next_st.suspend = 1'b0;
            next_st.busy = 1'b1;
            next_st.state = S_RUN;
          end else if (st.opcode == OP_STATUS_WRITE || isErase) begin
            next_st.state = S_SUSPENDED;
          end else if (isProgram) begin
            next_st.state = S_SUSPENDED;
          end
        end
      end

      S_PD_ENTER: begin
        if (st.lat <= 16'h1) begin
          next_st.state = S_PD;
          next_st.powerDown = 1'b1;
          next_st.statusReadable = 1'b0;
        end else begin
          next_st.lat = st.lat - 16'h1;
        end
      end

      S_PD: begin
        if (st.frameDone && st.opcode == OP_RELEASE && bareFrame) begin
          next_st.state = S_WAKE;
          next_st.lat = 16'(WAKE_CYC);
        end
      end

      S_WAKE: begin
        // Frames arriving here are dropped; the host must wait it out
        if (st.lat <= 16'h1) begin
          next_st.state = S_IDLE;
          next_st.powerDown = 1'b0;
          next_st.statusReadable = 1'b1;
        end else begin
          next_st.lat = st.lat - 16'h1;
        end
      end

      default: begin
        next_st.state = S_IDLE;
      end
    endcase

    // Set wins over the clear at the end of an operation
    if (writeLatchSet) begin
      next_st.writeLatch = 1'b1;
    end
  end

  // Reset doubles as power loss: suspend state is dropped, not resumed
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
      st.csSync <= 3'h7;
      st.state <= S_IDLE;
      st.runKind <= KIND_NONE;
      st.checkKind <= KIND_NONE;
      st.statusReadable <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign checkAddr = st.addr;
  assign checkKind = st.checkKind;
  assign busy = st.busy;
  assign writeLatchFlag = st.writeLatch;
  assign suspendFlag = st.suspend;
  assign statusReadable = st.statusReadable;
  assign powerDown = st.powerDown;
  assign eraseGo = st.eraseGo;
  assign eraseBase = st.eraseBase;
  assign eraseKind = st.runKind;
  assign programGo = st.programGo;
  assign statusWriteGo = st.statusWriteGo;
endmodule : fesp_sequencer

// *** dv/fesp_sequencer_sva.sv ***
// Port assertions for the erase, suspend and power-down sequencer.
// Assumes binding into fesp_sequencer, single clock/rst domain.
`timescale 1ns/1ps
module fesp_sequencer_sva
  import fesp_pkg::*;
#(
  parameter int SUSPEND_CYC = 5
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic writeLatchSet,
  input wire logic protectHit,
  input wire logic protectAny,
  input wire logic busy,
  input wire logic writeLatchFlag,
  input wire logic suspendFlag,
  input wire logic statusReadable,
  input wire logic powerDown,
  input wire logic eraseGo,
  input wire logic [23:0] eraseBase,
  input wire fesp_pkg::fesp_kind_e eraseKind,
  input wire logic statusWriteGo
);
  // One spare cycle for the flag register stage
  localparam int SUS_LIM = SUSPEND_CYC + 1;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence sus_drop_s;
    busy ##[1:SUS_LIM] !busy;
  endsequence
  sequence base_ok_s;
    (eraseKind == KIND_SECTOR && eraseBase[11:0] == 12'h000) ||
    (eraseKind == KIND_BLK32 && eraseBase[14:0] == 15'h0000) ||
    (eraseKind == KIND_BLK64 && eraseBase[15:0] == 16'h0000) ||
    (eraseKind == KIND_CHIP && eraseBase == 24'h000000);
  endsequence
  go_busy_a: assert property (eraseGo |-> busy)
    else $error("erase start without busy");
  go_latch_a: assert property (eraseGo |-> $past(writeLatchFlag))
    else $error("erase start with latch clear");
  base_align_a: assert property (eraseGo |-> base_ok_s)
    else $error("erase base misaligned");
  done_clear_a: assert property (
    $fell(busy) && !suspendFlag && !$past(writeLatchSet) |-> !writeLatchFlag)
    else $error("latch kept after erase");
  sus_drop_a: assert property ($rose(suspendFlag) |-> sus_drop_s)
    else $error("busy not dropped after suspend");
  sus_chip_a: assert property ($rose(suspendFlag) |-> eraseKind != KIND_CHIP)
    else $error("chip erase suspended");
  resume_busy_a: assert property ($fell(suspendFlag) |-> busy)
    else $error("resume without busy");
  susp_block_a: assert property (
    eraseGo || statusWriteGo |-> !suspendFlag)
    else $error("erase or status write while suspended");
  chip_prot_a: assert property (
    eraseGo && eraseKind == KIND_CHIP |-> !$past(protectAny))
    else $error("chip erase while protected");
  pd_status_a: assert property (powerDown |-> !statusReadable)
    else $error("status readable in power-down");
  rst_clear_a: assert property (
    $fell(rst) |-> !powerDown && !suspendFlag && !busy)
    else $error("state left after reset");
endmodule : fesp_sequencer_sva

// *** dv/fesp_host_model.sv ***
// Host serial controller model: chip select, serial clock, data.
// Assumes callers wait for each send to return before the next.
`timescale 1ns/1ps
module fesp_host_model (
  output logic sclk,
  output logic csN,
  output logic serialIn
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    serialIn = 1'b0;
    // Receiver has no reset; an empty frame presets its start marker
    #1 csN = 1'b0;
    #2 csN = 1'b1;
  end
  // MSB first; extra bits break the byte boundary on purpose
  task automatic send(input logic [7:0] q[$], input int extra);
    int k;
    int n;
    n = 8 * q.size() + extra;
    #7;
    csN = 1'b0;
    for (k = 0; k < n; k++) begin
      serialIn = (k / 8 < q.size()) ? q[k / 8][7 - k % 8] : 1'b1;
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    #24 csN = 1'b1;
    // Released line must not show a stale bit
    serialIn = ~serialIn;
    #200;
  endtask : send
endmodule : fesp_host_model

// *** dv/fesp_sequencer_test.sv ***
// Self-checking bench for the erase, suspend and power-down sequencer.
// Assumes the host model runs the link at 48 ns per bit.
`timescale 1ns/1ps
module fesp_sequencer_test;
  import fesp_pkg::*;
  localparam int SEC_C = 400;
  localparam int SUS_C = 5;
  localparam int B32_C = 500;
  localparam int B64_C = 600;
  localparam int CHP_C = 700;
  localparam int PRG_C = 200;
  localparam int PDE_C = 4;
  localparam int WAK_C = 4;
  logic [23:0] checkAddr;
  fesp_kind_e checkKind;
  logic clock, rst, sclk, csN, serialIn;
  logic writeLatchSet, protectHit, protectAny;
  logic [23:0] eraseBase;
  fesp_kind_e eraseKind;
  logic busy, writeLatchFlag, suspendFlag, statusReadable, powerDown;
  logic eraseGo, programGo, statusWriteGo;
  int badCount, numChecks, goCnt, swCnt, pgCnt;
  fesp_sequencer #(.SECTOR_CYC(SEC_C), .BLK32_CYC(B32_C), .BLK64_CYC(B64_C),
    .CHIP_CYC(CHP_C), .PROG_CYC(PRG_C), .SUSPEND_CYC(SUS_C),
    .PD_ENTRY_CYC(PDE_C), .WAKE_CYC(WAK_C)) fesp_sequencer_i (.clock(clock),
    .rst(rst), .sclk(sclk),
    .csN(csN), .serialIn(serialIn), .writeLatchSet(writeLatchSet),
    .protectHit(protectHit), .protectAny(protectAny), .checkAddr(checkAddr),
    .checkKind(checkKind), .busy(busy), .writeLatchFlag(writeLatchFlag),
    .suspendFlag(suspendFlag), .statusReadable(statusReadable),
    .powerDown(powerDown), .eraseGo(eraseGo), .eraseBase(eraseBase),
    .eraseKind(eraseKind), .programGo(programGo),
    .statusWriteGo(statusWriteGo));
  fesp_host_model host_i (.sclk(sclk), .csN(csN), .serialIn(serialIn));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    goCnt <= goCnt + int'(eraseGo);
    swCnt <= swCnt + int'(statusWriteGo);
    pgCnt <= pgCnt + int'(programGo);
  end
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic write_latch_flag();
    // Link sends end at any phase; realign before driving
    tick(1);
    writeLatchSet = 1'b1;
    tick(1);
    writeLatchSet = 1'b0;
    tick(1);
  endtask : write_latch_flag
  task automatic idle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      tick(1);
      n++;
    end
    chk("busy cleared", busy, 0);
  endtask : idle
  task automatic t_erase();
    logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
    fesp_kind_e kinds[5] = '{KIND_SECTOR, KIND_BLK32, KIND_BLK64,
      KIND_CHIP, KIND_CHIP};
    logic [23:0] bases[5] = '{24'h12a000, 24'h128000, 24'h120000,
      24'h000000, 24'h000000};
    int durs[5] = '{SEC_C, B32_C, B64_C, CHP_C, CHP_C};
    int g, n, i;
    for (i = 0; i < 5; i++) begin
      write_latch_flag();
      g = goCnt;
      if (i < 3) host_i.send('{ops[i], 8'h12, 8'ha5, 8'hc3}, 0);
      else host_i.send('{ops[i]}, 0);
      chk("erase started", goCnt - g, 1);
      chk("busy", busy, 1);
      chk("kind", eraseKind, kinds[i]);
      chk("base", eraseBase, bases[i]);
      chk("check kind", checkKind, kinds[i]);
      if (i < 3) chk("check addr", checkAddr, 24'h12a5c3);
      idle(n);
      chk("span", n >= durs[i] - 10 && n <= durs[i] - 3, 1);
      chk("latch", writeLatchFlag, 0);
    end
    $display("erase test done");
  endtask : t_erase
  task automatic t_refuse();
    int g, s;
    g = goCnt;
    s = swCnt;
    host_i.send('{8'h20, 8'h00, 8'h10, 8'h00}, 0);
    chk("no latch", goCnt - g, 0);
    write_latch_flag();
    protectHit = 1'b1;
    host_i.send('{8'h20, 8'h00, 8'h10, 8'h00}, 0);
    chk("protected", goCnt - g, 0);
    chk("latch kept", writeLatchFlag, 1);
    tick(1);
    protectHit = 1'b0;
    protectAny = 1'b1;
    host_i.send('{8'hc7}, 0);
    chk("chip protected", goCnt - g, 0);
    tick(1);
    protectAny = 1'b0;
    host_i.send('{8'h20, 8'h00, 8'h10, 8'h00}, 4);
    chk("ragged frame", goCnt - g, 0);
    chk("ragged busy", busy, 0);
    host_i.send('{8'h01, 8'h00}, 0);
    chk("status write", swCnt - s, 1);
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_suspend();
    int g, s, p, n;
    write_latch_flag();
    host_i.send('{8'h02, 8'h00, 8'h20, 8'h00, 8'h5a}, 0);
    host_i.send('{8'h75}, 0);
    p = pgCnt;
    write_latch_flag();
    host_i.send('{8'h32, 8'h00, 8'h20, 8'h00, 8'h5a}, 0);
    chk("prog in suspend", pgCnt - p, 0);
    host_i.send('{8'h7a}, 0);
    idle(n);
    write_latch_flag();
    host_i.send('{8'h20, 8'h00, 8'h30, 8'h00}, 0);
    host_i.send('{8'h75}, 0);
    chk("suspended", suspendFlag, 1);
    tick(2);
    chk("busy dropped", busy, 0);
    g = goCnt;
    s = swCnt;
    write_latch_flag();
    host_i.send('{8'h44, 8'h00, 8'h30, 8'h00}, 0);
    host_i.send('{8'h01, 8'h00}, 0);
    host_i.send('{8'h75}, 0);
    chk("erase in suspend", goCnt - g, 0);
    chk("status in suspend", swCnt - s, 0);
    chk("still suspended", suspendFlag, 1);
    host_i.send('{8'h7a}, 0);
    chk("resumed", suspendFlag, 0);
    chk("busy back", busy, 1);
    tick(SUS_C);
    host_i.send('{8'h7a}, 0);
    chk("resume ignored", suspendFlag, 0);
    idle(n);
    write_latch_flag();
    host_i.send('{8'h60}, 0);
    host_i.send('{8'h75}, 0);
    chk("chip not suspended", suspendFlag, 0);
    idle(n);
    write_latch_flag();
    host_i.send('{8'h52, 8'h01, 8'h00, 8'h00}, 0);
    host_i.send('{8'h75}, 0);
    tick(1);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    chk("flag lost", suspendFlag, 0);
    host_i.send('{8'h7a}, 0);
    chk("no resume", busy, 0);
    $display("suspend test done");
  endtask : t_suspend
  task automatic t_pd();
    int g;
    host_i.send('{8'hb9}, 0);
    tick(2);
    chk("power-down", powerDown, 1);
    chk("status off", statusReadable, 0);
    write_latch_flag();
    g = goCnt;
    host_i.send('{8'h20, 8'h00, 8'h00, 8'h00}, 0);
    chk("ignored", goCnt - g, 0);
    host_i.send('{8'hab}, 0);
    tick(2);
    chk("awake", powerDown, 0);
    chk("status on", statusReadable, 1);
    $display("power-down test done");
  endtask : t_pd
  task automatic conclude();
    $display("checks %0d, mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    rst = 1'b1;
    writeLatchSet = 1'b0;
    protectHit = 1'b0;
    protectAny = 1'b0;
    {badCount, numChecks, goCnt, swCnt, pgCnt} = '0;
    tick(5);
    rst = 1'b0;
    chk("normal after reset", powerDown, 0);
    t_erase();
    t_refuse();
    t_suspend();
    t_pd();
    conclude();
  end
  // Whole run needs well under 0.3 ms
  initial begin
    #1ms;
    badCount++;
    conclude();
  end
endmodule : fesp_sequencer_test
bind fesp_sequencer fesp_sequencer_sva #(.SUSPEND_CYC(SUSPEND_CYC))
  fesp_sequencer_sva_i (.clock(clock), .rst(rst),
  .writeLatchSet(writeLatchSet), .protectHit(protectHit),
  .protectAny(protectAny), .busy(busy), .writeLatchFlag(writeLatchFlag),
  .suspendFlag(suspendFlag), .statusReadable(statusReadable),
  .powerDown(powerDown), .eraseGo(eraseGo), .eraseBase(eraseBase),
  .eraseKind(eraseKind), .statusWriteGo(statusWriteGo));
